//--- hw/adc_pins_pkg.sv
// Package for the dual converter pin interface: modes, timing and carriers
package adc_pins_pkg;

    localparam int RES_FULL      = 16;
    localparam int RES_MID       = 14;
    localparam int RES_SMALL     = 12;
    localparam int STORE_DEPTH   = 4;
    localparam int CH_PER_ADC    = 4;
    localparam int CH_DIFF       = 2;
    // Conversion length in half clock periods of the converter clock
    localparam int CONV_HALF_HALFCLK = 35;
    localparam int CONV_HALF_FULLCLK = 70;
    localparam int CNT_W         = 8;

    typedef enum logic [1:0] {
        ST_SAMPLE,
        ST_HOLD,
        ST_CONVERT
    } conv_state_t;

    typedef struct packed {
        logic conversionStart;
        logic clockRise;
        logic halfClockMode;
    } conv_ctrl_t;

    typedef struct packed {
        logic serialResultOutA;
        logic serialResultOutAEn;
        logic serialResultOutB;
        logic serialResultOutBEn;
    } serial_out_t;

endpackage : adc_pins_pkg

//--- hw/dual_adc_pin_interface.sv
// Dual simultaneous-sampling converter: conversion sequencing and serial pins
`timescale 1ns/1ps
module dual_adc_pin_interface
    import adc_pins_pkg::*;
#(
    parameter int RES_BITS = RES_FULL,
    parameter int CFG_BITS = 16
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    // Conversion control, converter clock sampled as a level
    input  wire adc_pins_pkg::conv_ctrl_t  convCtrl,
    output logic                           busy,
    // Mode pins
    input  wire logic                      inputConfigPin,
    input  wire logic                      outputConfigPin,
    // Serial host side
    input  wire logic                      chipSelect_n,
    input  wire logic                      readSync,
    input  wire logic                      serialConfigIn,
    output adc_pins_pkg::serial_out_t      serialOut,
    // Converter core side
    input  wire logic [RES_BITS-1:0]       coreResultA,
    input  wire logic [RES_BITS-1:0]       coreResultB,
    output logic                           holdInputs,
    output logic [1:0]                     channelSelect,
    output logic                           differentialMode,
    output logic [CFG_BITS-1:0]            configWord
);
    import adc_pins_pkg::*;

    initial begin
        if (RES_BITS != RES_FULL && RES_BITS != RES_MID && RES_BITS != RES_SMALL)
            $error("RES_BITS must be 16, 14 or 12");
        if (CFG_BITS < 2)
            $error("CFG_BITS too small");
        if (STORE_DEPTH < 2)
            $error("STORE_DEPTH must hold at least two results");
        if (CONV_HALF_FULLCLK >= (1 << CNT_W))
            $error("CNT_W too narrow for the conversion count");
        if (CH_DIFF > CH_PER_ADC)
            $error("differential channel count exceeds pseudo channel count");
    end

    function automatic logic [1:0] wrapChan(input logic [1:0] c, input logic diff);
        wrapChan = diff ? ((c == 2'(CH_DIFF - 1)) ? 2'h0 : c + 2'h1) : c + 2'h1;
    endfunction : wrapChan

    conv_state_t             state, next_state;
    logic [CNT_W-1:0]        halfCnt, next_halfCnt;
    logic                    startPrev, next_startPrev;
    logic                    clkPrev, next_clkPrev;
    logic [1:0]              chan, next_chan;
    logic [RES_BITS-1:0]     storeA [STORE_DEPTH], next_storeA [STORE_DEPTH];
    logic [RES_BITS-1:0]     storeB [STORE_DEPTH], next_storeB [STORE_DEPTH];
    logic [RES_BITS-1:0]     shiftA, next_shiftA;
    logic [RES_BITS-1:0]     shiftB, next_shiftB;
    logic [CFG_BITS-1:0]     cfgShift, next_cfgShift;
    logic [CFG_BITS-1:0]     cfgReg, next_cfgReg;
    logic                    syncPrev, next_syncPrev;
    localparam int           IDX_W = $clog2(STORE_DEPTH);
    logic [IDX_W-1:0]        readIdx, next_readIdx;
    logic                    clkEdge, readPulse, selected, convDone;
    logic [CNT_W-1:0]        convHalves;

    // Edge detection compares each pin with its sample from the previous clk
    assign selected   = !chipSelect_n;
    assign clkEdge    = convCtrl.clockRise && !clkPrev;
    assign readPulse  = selected && readSync && !syncPrev;
    assign convHalves = convCtrl.halfClockMode ? CNT_W'(CONV_HALF_HALFCLK)
                                               : CNT_W'(CONV_HALF_FULLCLK);

    // Last counted clock rise of a conversion; both result stores take their word here
    assign convDone   = (state == ST_CONVERT) && clkEdge
                        && ((halfCnt + CNT_W'(2)) >= convHalves);

    always_comb begin
        next_state     = state;
        next_halfCnt   = halfCnt;
        next_startPrev = convCtrl.conversionStart;
        next_clkPrev   = convCtrl.clockRise;
        next_chan      = chan;
        next_storeA    = storeA;
        next_storeB    = storeB;
        case (state)
            ST_SAMPLE: begin
                if (convCtrl.conversionStart && !startPrev)
                    next_state = ST_HOLD;
            end
            ST_HOLD: begin
                if (clkEdge) begin
                    next_state   = ST_CONVERT;
                    next_halfCnt = '0;
                end
            end
            ST_CONVERT: begin
                // Each converter clock rise counts two half periods
                if (clkEdge)
                    next_halfCnt = halfCnt + CNT_W'(2);
                if (convDone) begin
                    next_state = ST_SAMPLE;
                    // Both results land together, shifting the oversampling history
                    for (int i = STORE_DEPTH - 1; i > 0; i--) begin
                        next_storeA[i] = storeA[i-1];
                        next_storeB[i] = storeB[i-1];
                    end
                    next_storeA[0] = coreResultA;
                    next_storeB[0] = coreResultB;
                    next_chan = wrapChan(chan, inputConfigPin);
                end
            end
            default: next_state = ST_SAMPLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state     <= ST_SAMPLE;
            halfCnt   <= '0;
            startPrev <= 1'b0;
            clkPrev   <= 1'b0;
            chan      <= 2'h0;
            for (int i = 0; i < STORE_DEPTH; i++) begin
                storeA[i] <= '0;
                storeB[i] <= '0;
            end
        end else begin
            state     <= next_state;
            halfCnt   <= next_halfCnt;
            startPrev <= next_startPrev;
            clkPrev   <= next_clkPrev;
            chan      <= next_chan;
            storeA    <= next_storeA;
            storeB    <= next_storeB;
        end
    end

    // Hold covers the wait for the clock edge and the conversion itself
    assign busy             = (state != ST_SAMPLE);
    assign holdInputs       = (state != ST_SAMPLE);
    assign channelSelect    = chan;
    assign differentialMode = inputConfigPin;
    assign configWord       = cfgReg;

    always_comb begin
        next_syncPrev = readSync;
        next_shiftA   = shiftA;
        next_shiftB   = shiftB;
        next_cfgShift = cfgShift;
        next_cfgReg   = cfgReg;
        if (readPulse) begin
            next_shiftA   = storeA[readIdx];
            // Single-output mode sends both results back to back on output A
            next_shiftB   = storeB[readIdx];
            next_cfgReg   = cfgShift;
        end else if (selected && clkEdge) begin
            next_shiftA   = outputConfigPin ? {shiftA[RES_BITS-2:0], shiftB[RES_BITS-1]}
                                            : {shiftA[RES_BITS-2:0], 1'b0};
            next_shiftB   = {shiftB[RES_BITS-2:0], 1'b0};
            next_cfgShift = {cfgShift[CFG_BITS-2:0], serialConfigIn};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syncPrev <= 1'b0;
            shiftA   <= '0;
            shiftB   <= '0;
            cfgShift <= '0;
            cfgReg   <= '0;
        end else begin
            syncPrev <= next_syncPrev;
            shiftA   <= next_shiftA;
            shiftB   <= next_shiftB;
            cfgShift <= next_cfgShift;
            cfgReg   <= next_cfgReg;
        end
    end

    // A fresh conversion rewinds the pointer, so the first read-sync gets the newest pair;
    // each further read-sync steps one result older and sticks at the oldest
    // Reads do not wait for busy; a read during a conversion returns the previous pair
    // A read-sync on the conversion's last edge still uses the old pointer once
    always_comb begin
        next_readIdx = readIdx;
        if (convDone)
            next_readIdx = '0;
        else if (readPulse && readIdx != IDX_W'(STORE_DEPTH - 1))
            next_readIdx = readIdx + IDX_W'(1);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readIdx <= '0;
        end else begin
            readIdx <= next_readIdx;
        end
    end

    assign serialOut.serialResultOutA   = shiftA[RES_BITS-1];
    assign serialOut.serialResultOutAEn = selected;
    assign serialOut.serialResultOutB   = shiftB[RES_BITS-1];
    assign serialOut.serialResultOutBEn = selected && !outputConfigPin;

endmodule : dual_adc_pin_interface

//--- verif/adc_host_clock.sv
// Host model: converter clock source, low outside frames
`timescale 1ns/1ps
module adc_host_clock #(
    parameter int DIV = 8
) (
    input  wire logic clk,
    input  wire logic run,
    output logic      clkPin = 1'b0
);
    int cnt = 0;
    // Half period of DIV cycles keeps the pin inside both clock ranges
    always @(negedge clk) begin
        if (!run) begin
            clkPin <= 1'b0;
            cnt    <= 0;
        end else if (cnt == DIV - 1) begin
            clkPin <= !clkPin;
            cnt    <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : adc_host_clock

//--- verif/dual_adc_pin_interface_assertions.sv
// Checker for the dual converter pin interface
`timescale 1ns/1ps
module dual_adc_pin_interface_assertions
    import adc_pins_pkg::*;
#(
    parameter int CFG_BITS = 16
) (
    input wire logic                      clk,
    input wire logic                      arst_n,
    input wire adc_pins_pkg::conv_ctrl_t  convCtrl,
    input wire logic                      busy,
    input wire logic                      holdInputs,
    input wire logic                      inputConfigPin,
    input wire logic                      outputConfigPin,
    input wire logic                      chipSelect_n,
    input wire logic                      readSync,
    input wire adc_pins_pkg::serial_out_t serialOut,
    input wire logic                      differentialMode,
    input wire logic [CFG_BITS-1:0]       configWord
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_start; $rose(convCtrl.conversionStart) && !busy |=> busy; endproperty
    a_start: assert property (p_start)
        else $error("busy did not rise after start");
    property p_hold; holdInputs == busy; endproperty
    a_hold: assert property (p_hold)
        else $error("hold differs from busy");
    property p_conv; $rose(busy) |-> busy[*8] ##[1:1000] !busy; endproperty
    a_conv: assert property (p_conv)
        else $error("conversion length out of bounds");
    property p_hiz; chipSelect_n |-> !serialOut.serialResultOutAEn
        && !serialOut.serialResultOutBEn; endproperty
    a_hiz: assert property (p_hiz)
        else $error("output driven while deselected");
    property p_aen; !chipSelect_n |-> serialOut.serialResultOutAEn; endproperty
    a_aen: assert property (p_aen)
        else $error("output A idle while selected");
    property p_ben; serialOut.serialResultOutBEn == (!chipSelect_n && !outputConfigPin);
    endproperty
    a_ben: assert property (p_ben)
        else $error("output B enable wrong");
    property p_mode; differentialMode == inputConfigPin; endproperty
    a_mode: assert property (p_mode)
        else $error("channel mode differs from pin");
    property p_cfg; chipSelect_n |-> $stable(configWord); endproperty
    a_cfg: assert property (p_cfg)
        else $error("config changed while deselected");
    c_conv: cover property ($fell(busy));
    c_read: cover property ($rose(readSync) && !chipSelect_n);
    c_single: cover property (!chipSelect_n && outputConfigPin);
endmodule : dual_adc_pin_interface_assertions
bind dual_adc_pin_interface dual_adc_pin_interface_assertions #(.CFG_BITS(CFG_BITS)) chk (
    .clk, .arst_n, .convCtrl, .busy, .holdInputs, .inputConfigPin, .outputConfigPin,
    .chipSelect_n, .readSync, .serialOut, .differentialMode, .configWord);

//--- verif/testbench.sv
// Self-checking bench for the dual converter pin interface
`timescale 1ns/1ps
module testbench;
    import adc_pins_pkg::*;
    logic        clk = 1'b0, arst_n = 1'b0, start = 1'b0, halfMode = 1'b0, run = 1'b0;
    logic        inCfg = 1'b0, outCfg = 1'b0, csN = 1'b1, rsync = 1'b0, serial_config_in = 1'b0;
    logic        clkPin, busy;
    logic [1:0]  chanSel;
    logic [15:0] resA = 16'hA5C3, resB = 16'h3C5A, cfg = 16'h5A3C, cfgWord;
    int          failures = 0, comparisons = 0, rises = 0;
    conv_ctrl_t  ctrl;
    serial_out_t so;
    assign ctrl = '{start, clkPin, halfMode};
    always #2 clk = ~clk;
    always @(posedge clkPin) if (busy === 1'b1) rises++;
    adc_host_clock host (.clk, .run, .clkPin);
    dual_adc_pin_interface uut (.clk, .arst_n, .convCtrl(ctrl), .busy, .inputConfigPin(inCfg),
        .outputConfigPin(outCfg), .chipSelect_n(csN), .readSync(rsync), .serialConfigIn(serial_config_in),
        .serialOut(so), .coreResultA(resA), .coreResultB(resB), .holdInputs(),
        .channelSelect(chanSel), .differentialMode(), .configWord(cfgWord));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task report_and_stop;
        if (failures == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task convert(input logic half, input int expRises);
        int n;
        halfMode = half;
        rises = 0;
        start = 1'b1;
        @(negedge clk) start = 1'b0;
        @(negedge clk) check(busy, 1);
        run = 1'b1;
        // Second start while busy must be ignored
        @(negedge clk) start = 1'b1;
        for (n = 0; n < 2000 && busy === 1'b1; n++) @(negedge clk);
        start = 1'b0;
        run = 1'b0;
        check(busy, 0);
        check(rises, expRises);
    endtask : convert
    task read(input int nb, input logic [31:0] expA, input logic [15:0] expB,
              input logic expOld);
        int i;
        csN = 1'b0;
        @(negedge clk) rsync = 1'b1;
        repeat (2) @(negedge clk);
        run = 1'b1;
        for (i = nb - 1; i >= 0; i--) begin
            check(so.serialResultOutA, expA[i]);
            if (nb == 16) check(so.serialResultOutB, expB[i]);
            serial_config_in = cfg[i % 16];
            @(posedge clkPin);
            repeat (2) @(negedge clk);
        end
        run = 1'b0;
        rsync = 1'b0;
        @(negedge clk) rsync = 1'b1;
        repeat (2) @(negedge clk);
        check(cfgWord, cfg);
        check(so.serialResultOutA, expOld);
        csN = 1'b1;
        rsync = 1'b0;
    endtask : read
    initial begin
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk) check(so.serialResultOutAEn, 0);
        convert(1'b1, 19);
        check(chanSel, 2'h1);
        read(16, {16'h0000, resA}, resB, 1'b0);
        outCfg = 1'b1;
        inCfg = 1'b1;
        resA = 16'h1234;
        convert(1'b0, 36);
        check(chanSel, 2'h0);
        read(32, {resA, resB}, resB, 1'b1);
        cfg = 16'h0000;
        @(negedge clk) rsync = 1'b1;
        repeat (2) @(negedge clk);
        check(cfgWord, 16'h5A3C);
        report_and_stop();
    end
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
endmodule : testbench
